// ===== common/dee_cfg.svh
// How it works
// R01 - Reset during write sets write error flag
// R02 - Control bit 2 enables array writes
// R03 - Bit 1 starts write, hardware clears
// R04 - Bit 0 starts one-cycle read, self-clears
// R05 - CPU loads address before setting read
// R06 - Read byte lands in data register next
// R07 - Data register holds until read or write
// R08 - CPU loads address and data before writing
// R09 - Write needs 55h, AAh, then start
// R10 - Mistimed unlock sequence refuses the write
// R11 - CPU should mask interrupts during unlock
// R12 - Write start needs write enable set
// R13 - Enable never hardware-cleared, no abort
// R14 - Software keeps write enable normally clear
// R15 - Completion clears start, sets complete flag
// R16 - Complete flag sticky until software clears
// R17 - Power-up clears enable, timer blocks writes
// R18 - Code protect leaves CPU access intact
// R19 - Unlock port stores nothing
// R20 - Counted write duration, reset abort flags
// R21 - Interrupt needs flag and enable both
`ifndef DEE_CFG_SVH
`define DEE_CFG_SVH

// ==========================
// Register byte offsets
`define DEE_OFS_GIC 8'h00
`define DEE_OFS_FLG 8'h04
`define DEE_OFS_ENA 8'h08
`define DEE_OFS_DAT 8'h0C
`define DEE_OFS_ADR 8'h10
`define DEE_OFS_CON 8'h14
`define DEE_OFS_KEY 8'h18
`define DEE_OFS_CFG 8'h1C

// ==========================
// Field positions
`define DEE_CON_RD 0
`define DEE_CON_WR 1
`define DEE_CON_WRITE_ENABLE_BIT 2
`define DEE_CON_ERR 3
`define DEE_FLG_DONE 7
`define DEE_ENA_DONE 7

// ==========================
// Values
`define DEE_RST_BYTE 8'h00
`define DEE_KEY_FIRST 8'h55
`define DEE_KEY_SECOND 8'hAA
`define DEE_RESP_OKAY 2'b00
`define DEE_RESP_SLVERR 2'b10

// ==========================
// Timing
`define DEE_CLK_MHZ 125
`define DEE_PWRT_MS 64
`define DEE_PWRT_CYCLES (`DEE_PWRT_MS * `DEE_CLK_MHZ * 1000)
`define DEE_WRITE_CYCLES 16
`define DEE_KEY_WINDOW 16
`define DEE_CNT_W 24

`endif

// ===== common/dee_pkg.sv
`include "dee_cfg.svh"

package dee_pkg;

   typedef enum logic [1:0] {DEE_LK_IDLE, DEE_LK_KEY1, DEE_LK_KEY2} dee_lock_t;

   // Non-power-on reset sources that abort a write
   typedef struct packed {
      logic master_clear_reset;
      logic watchdog_reset;
      logic brownout_reset;
   } dee_rst_src_t;

   typedef struct packed {
      logic aw_got;
      logic [7:0] aw_addr;
      logic w_got;
      logic [7:0] w_byte;
      logic w_lane;
      logic bvalid;
      logic [1:0] bresp;
      logic rvalid;
      logic [7:0] rbyte;
      logic [1:0] rresp;
      logic [7:0] gic;
      logic done_flag;
      logic done_en;
      logic [7:0] data;
      logic [7:0] addr;
      logic err;
      logic write_enable_bit;
      logic wr;
      logic rd;
      dee_lock_t lock;
      logic [`DEE_CNT_W-1:0] lock_cnt;
      logic [`DEE_CNT_W-1:0] wcnt;
      logic [7:0] w_addr;
      logic [7:0] w_data;
      logic [`DEE_CNT_W-1:0] pwrt_cnt;
      logic pwrt_done;
   } dee_state_t;

endpackage

// ===== logic/dee_array.sv
`timescale 1ns/100ps
`default_nettype none

// Byte array: combinational read, one write port
module dee_array #(
   parameter int DEPTH = 256,
   parameter int AW = 8
) (
   input wire logic aclk,
   input wire logic we,
   input wire logic [AW-1:0] waddr,
   input wire logic [7:0] wdata,
   input wire logic [AW-1:0] raddr,
   output logic [7:0] rdata
);

   logic [7:0] mem [DEPTH];

   // Contents are not reset; nonvolatile cells keep data
   always_ff @(posedge aclk)
   begin
      if (we)
      begin
         mem[waddr] <= wdata;
      end
   end

   assign rdata = mem[raddr];

endmodule

`default_nettype wire

// ===== logic/dee_ctrl.sv
`timescale 1ns/100ps
`default_nettype none
`include "dee_cfg.svh"

module dee_ctrl #(
   parameter int PWRT_CYCLES = `DEE_PWRT_CYCLES,
   parameter int WRITE_CYCLES = `DEE_WRITE_CYCLES,
   parameter int KEY_WINDOW = `DEE_KEY_WINDOW
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   output logic awready,
   input wire logic [7:0] awaddr,
   input wire logic [2:0] awprot,
   input wire logic wvalid,
   output logic wready,
   input wire logic [31:0] wdata,
   input wire logic [3:0] wstrb,
   output logic bvalid,
   input wire logic bready,
   output logic [1:0] bresp,
   input wire logic arvalid,
   output logic arready,
   input wire logic [7:0] araddr,
   input wire logic [2:0] arprot,
   output logic rvalid,
   input wire logic rready,
   output logic [31:0] rdata,
   output logic [1:0] rresp,
   input wire dee_pkg::dee_rst_src_t rst_src,
   input wire logic data_code_protect_bit,
   output logic irq
);

   // ==========================
   // State and array
   dee_pkg::dee_state_t s_reg;
   dee_pkg::dee_state_t s_next;
   logic mem_we;
   logic [7:0] mem_q;
   logic abort_req;
   logic [7:0] rd_val;
   logic unused_prot;

   assign unused_prot = ^{awprot, arprot, wdata[31:8], wstrb[3:1]};

   dee_array #(
      .DEPTH(256),
      .AW(8)
   ) u_array (
      .aclk(aclk),
      .we(mem_we),
      .waddr(s_reg.w_addr),
      .wdata(s_reg.w_data),
      .raddr(s_reg.addr),
      .rdata(mem_q)
   );

   // ==========================
   // Address decode
   function automatic logic dee_mapped(input logic [7:0] a);
      case (a)
         `DEE_OFS_GIC, `DEE_OFS_FLG, `DEE_OFS_ENA, `DEE_OFS_DAT,
         `DEE_OFS_ADR, `DEE_OFS_CON, `DEE_OFS_KEY, `DEE_OFS_CFG:
            dee_mapped = 1'b1;
         default:
            dee_mapped = 1'b0;
      endcase
   endfunction

   function automatic logic [`DEE_CNT_W-1:0] dee_last(input int n);
      dee_last = `DEE_CNT_W'(n - 1);
   endfunction

   assign abort_req = rst_src.master_clear_reset | rst_src.watchdog_reset | rst_src.brownout_reset;

   // ==========================
   // Read mux
   always_comb
   begin
      rd_val = `DEE_RST_BYTE;
      case (araddr)
         `DEE_OFS_GIC:
            rd_val = s_reg.gic;
         `DEE_OFS_FLG:
            rd_val[`DEE_FLG_DONE] = s_reg.done_flag;
         `DEE_OFS_ENA:
            rd_val[`DEE_ENA_DONE] = s_reg.done_en;
         `DEE_OFS_DAT:
            rd_val = s_reg.data;
         `DEE_OFS_ADR:
            rd_val = s_reg.addr;
         `DEE_OFS_CON:
         begin
            rd_val[`DEE_CON_ERR] = s_reg.err;
            rd_val[`DEE_CON_WRITE_ENABLE_BIT] = s_reg.write_enable_bit;
            rd_val[`DEE_CON_WR] = s_reg.wr;
            rd_val[`DEE_CON_RD] = s_reg.rd;
         end
         // Unlock port reads as zero
         `DEE_OFS_KEY:
            rd_val = `DEE_RST_BYTE; // R19
         // Protection is visible only; access stays open
         `DEE_OFS_CFG:
            rd_val[0] = data_code_protect_bit; // R18
         default:
            rd_val = `DEE_RST_BYTE;
      endcase
   end

   // ==========================
   // Next state
   always_comb
   begin
      s_next = s_reg;
      mem_we = 1'b0;
      s_next.rd = 1'b0; // R04

      // Power-up timer
      if (!s_reg.pwrt_done)
      begin
         s_next.pwrt_cnt = s_reg.pwrt_cnt + `DEE_CNT_W'(1);
         if (s_reg.pwrt_cnt == dee_last(PWRT_CYCLES))
         begin
            s_next.pwrt_done = 1'b1; // R17
         end
      end

      // Unlock window; a late step drops the sequence
      if (s_reg.lock != dee_pkg::DEE_LK_IDLE)
      begin
         s_next.lock_cnt = s_reg.lock_cnt + `DEE_CNT_W'(1);
         if (s_reg.lock_cnt == dee_last(KEY_WINDOW))
         begin
            s_next.lock = dee_pkg::DEE_LK_IDLE; // R10
         end
      end

      // Bus channels
      if (awvalid && !s_reg.aw_got && !s_reg.bvalid)
      begin
         s_next.aw_got = 1'b1;
         s_next.aw_addr = awaddr;
      end
      if (wvalid && !s_reg.w_got && !s_reg.bvalid)
      begin
         s_next.w_got = 1'b1;
         s_next.w_byte = wdata[7:0];
         s_next.w_lane = wstrb[0];
      end
      if (s_reg.bvalid && bready)
      begin
         s_next.bvalid = 1'b0;
      end
      if (arvalid && !s_reg.rvalid)
      begin
         s_next.rvalid = 1'b1;
         s_next.rbyte = rd_val;
         s_next.rresp = dee_mapped(araddr) ? `DEE_RESP_OKAY : `DEE_RESP_SLVERR;
      end
      else if (s_reg.rvalid && rready)
      begin
         s_next.rvalid = 1'b0;
      end

      // Register write, one cycle after both halves arrive
      if (s_reg.aw_got && s_reg.w_got && !s_reg.bvalid)
      begin
         s_next.aw_got = 1'b0;
         s_next.w_got = 1'b0;
         s_next.bvalid = 1'b1;
         s_next.bresp = dee_mapped(s_reg.aw_addr) ? `DEE_RESP_OKAY : `DEE_RESP_SLVERR;
         if (s_reg.w_lane && dee_mapped(s_reg.aw_addr))
         begin
            // Any strobed write to a mapped register other than the next key step breaks the sequence
            if (s_reg.aw_addr != `DEE_OFS_KEY)
            begin
               s_next.lock = dee_pkg::DEE_LK_IDLE; // R09
            end
            case (s_reg.aw_addr)
               `DEE_OFS_GIC:
                  s_next.gic = s_reg.w_byte;
               `DEE_OFS_FLG:
                  s_next.done_flag = s_reg.w_byte[`DEE_FLG_DONE]; // R16
               `DEE_OFS_ENA:
                  s_next.done_en = s_reg.w_byte[`DEE_ENA_DONE];
               `DEE_OFS_DAT:
                  s_next.data = s_reg.w_byte; // R07
               `DEE_OFS_ADR:
                  s_next.addr = s_reg.w_byte;
               `DEE_OFS_CON:
               begin
                  s_next.err = s_reg.w_byte[`DEE_CON_ERR];
                  // Software clearing enable leaves a running write alone
                  s_next.write_enable_bit = s_reg.w_byte[`DEE_CON_WRITE_ENABLE_BIT]; // R02 R13
                  if (s_reg.w_byte[`DEE_CON_RD])
                  begin
                     s_next.rd = 1'b1; // R04
                     s_next.data = mem_q; // R06
                  end
                  // Start only with enable already set, full unlock, timer expired
                  if (s_reg.w_byte[`DEE_CON_WR] && !s_reg.wr && s_reg.write_enable_bit &&
                      s_reg.lock == dee_pkg::DEE_LK_KEY2 && s_reg.pwrt_done)
                  begin
                     s_next.wr = 1'b1; // R03 R12 R09 R17
                     s_next.wcnt = '0;
                     s_next.w_addr = s_reg.addr;
                     s_next.w_data = s_reg.data;
                  end
               end
               // Key port only steers the sequence detector
               `DEE_OFS_KEY:
               begin
                  s_next.lock_cnt = '0; // R19
                  if (s_reg.w_byte == `DEE_KEY_FIRST)
                  begin
                     s_next.lock = dee_pkg::DEE_LK_KEY1; // R09
                  end
                  else if (s_reg.w_byte == `DEE_KEY_SECOND && s_reg.lock == dee_pkg::DEE_LK_KEY1)
                  begin
                     s_next.lock = dee_pkg::DEE_LK_KEY2; // R09
                  end
                  else
                  begin
                     s_next.lock = dee_pkg::DEE_LK_IDLE; // R10
                  end
               end
               default:
                  s_next.lock = dee_pkg::DEE_LK_IDLE;
            endcase
         end
      end

      // Write cycle; hardware events come last so they beat software writes
      if (s_reg.wr)
      begin
         s_next.wcnt = s_reg.wcnt + `DEE_CNT_W'(1);
         if (abort_req)
         begin
            s_next.wr = 1'b0; // R20
            s_next.err = 1'b1; // R01
         end
         else if (s_reg.wcnt == dee_last(WRITE_CYCLES))
         begin
            mem_we = 1'b1; // R20
            s_next.wr = 1'b0; // R15
            s_next.done_flag = 1'b1; // R15 R16
            s_next.err = 1'b0; // R01
         end
      end
   end

   // ==========================
   // State register
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_reg <= '0;
         s_reg.lock <= dee_pkg::DEE_LK_IDLE;
         s_reg.write_enable_bit <= 1'b0; // R17
         s_reg.pwrt_done <= 1'b0; // R17
      end
      else
      begin
         s_reg <= s_next;
      end
   end

   // ==========================
   // Outputs
   assign awready = !s_reg.aw_got && !s_reg.bvalid;
   assign wready = !s_reg.w_got && !s_reg.bvalid;
   assign arready = !s_reg.rvalid;
   assign bvalid = s_reg.bvalid;
   assign bresp = s_reg.bresp;
   assign rvalid = s_reg.rvalid;
   assign rdata = {24'h000000, s_reg.rbyte};
   assign rresp = s_reg.rresp;
   assign irq = s_reg.done_flag & s_reg.done_en; // R21

endmodule

`default_nettype wire

// ===== test/dee_ctrl_checker.sv
`timescale 1ns/100ps
`default_nettype none

// ======
// Bus handshake checks
module dee_ctrl_checker (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic awvalid,
   input wire logic awready,
   input wire logic wvalid,
   input wire logic wready,
   input wire logic bvalid,
   input wire logic bready,
   input wire logic arvalid,
   input wire logic arready,
   input wire logic rvalid,
   input wire logic rready,
   input wire logic [31:0] rdata
);
   default clocking cb @(posedge aclk);
   endclocking
   default disable iff (!aresetn);

   sequence s_wr_taken;
      awvalid && awready && wvalid && wready;
   endsequence
   sequence s_resp_gap;
      !bvalid ##1 bvalid;
   endsequence

   a_write_answer: assert property (s_wr_taken |=> s_resp_gap)
      else $error("write response late");
   a_read_answer: assert property (arvalid && arready |=> rvalid)
      else $error("read data late");
   a_bresp_holds: assert property (bvalid && !bready |=> bvalid)
      else $error("write response dropped");
   a_rdata_holds: assert property (rvalid && !rready |=> rvalid && $stable(rdata))
      else $error("read data not held");
   a_bresp_closes: assert property (bvalid && bready |=> !bvalid)
      else $error("write response repeated");
   a_rdata_closes: assert property (rvalid && rready |=> !rvalid)
      else $error("read data repeated");
   a_write_blocked: assert property (bvalid |-> !awready && !wready)
      else $error("write taken while busy");
   a_read_blocked: assert property (rvalid |-> !arready)
      else $error("read taken while busy");
   a_rdata_upper: assert property (rvalid |-> rdata[31:8] == 24'h0)
      else $error("upper read bits set");
endmodule

bind dee_ctrl dee_ctrl_checker dee_ctrl_checker_inst (.aclk(aclk), .aresetn(aresetn),
   .awvalid(awvalid), .awready(awready), .wvalid(wvalid), .wready(wready), .bvalid(bvalid),
   .bready(bready), .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
   .rdata(rdata));

`default_nettype wire

// ===== test/dee_cpu_model.sv
`timescale 1ns/100ps
`default_nettype none

// ======
// CPU side: one bus access at a time
module dee_cpu_model (
   input wire logic aclk,
   output logic awvalid,
   input wire logic awready,
   output logic [7:0] awaddr,
   output logic wvalid,
   input wire logic wready,
   output logic [31:0] wdata,
   input wire logic bvalid,
   output logic bready,
   input wire logic [1:0] bresp,
   output logic [1:0] wresp,
   output logic arvalid,
   input wire logic arready,
   output logic [7:0] araddr,
   input wire logic rvalid,
   output logic rready,
   input wire logic [31:0] rdata,
   input wire logic [1:0] rresp,
   output logic hung
);
   initial
   begin
      awvalid = 1'b0;
      wvalid = 1'b0;
      bready = 1'b0;
      arvalid = 1'b0;
      rready = 1'b0;
      awaddr = 8'h00;
      araddr = 8'h00;
      wdata = 32'h0;
      wresp = 2'b11;
      hung = 1'b0;
   end

   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      int n;
      @(posedge aclk);
      awaddr <= a;
      wdata <= {24'h0, d};
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      for (n = 0; n < 64; n++)
      begin
         @(posedge aclk);
         if (awready)
            awvalid <= 1'b0;
         if (wready)
            wvalid <= 1'b0;
         if (bvalid)
            break;
      end
      // Response code is taken at the edge that ends the handshake
      wresp = bresp;
      bready <= 1'b0;
      hung <= hung | (n == 64);
   endtask

   task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
      int n;
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      for (n = 0; n < 64; n++)
      begin
         @(posedge aclk);
         if (arready)
            arvalid <= 1'b0;
         if (rvalid)
            break;
      end
      d = rdata;
      r = rresp;
      rready <= 1'b0;
      hung <= hung | (n == 64);
   endtask
endmodule

`default_nettype wire

// ===== test/data_eeprom_access_control_test.sv
`timescale 1ns/100ps
`default_nettype none
`include "dee_cfg.svh"

module data_eeprom_access_control_test;
   // Short timer keeps the run brief
   localparam int PWRT = 200;
   localparam int KW = 8;
   logic aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready, cpb, irq, hung;
   logic arvalid, arready, rvalid, rready;
   logic [7:0] awaddr, araddr;
   logic [31:0] wdata, rdata, v;
   logic [1:0] rresp, rs, bresp, wresp;
   dee_pkg::dee_rst_src_t rst_src;
   int miscompares, check_count;

   dee_ctrl #(.PWRT_CYCLES(PWRT), .KEY_WINDOW(KW)) dee_ctrl_inst (.aclk(aclk), .aresetn(aresetn),
      .awvalid(awvalid), .awready(awready), .awaddr(awaddr), .awprot(3'h0), .wvalid(wvalid),
      .wready(wready), .wdata(wdata), .wstrb(4'hF), .bvalid(bvalid), .bready(bready), .bresp(bresp),
      .arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(3'h0), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp), .rst_src(rst_src), .data_code_protect_bit(cpb),
      .irq(irq));
   dee_cpu_model dee_cpu_model_inst (.aclk(aclk), .awvalid(awvalid), .awready(awready),
      .awaddr(awaddr), .wvalid(wvalid), .wready(wready), .wdata(wdata), .bvalid(bvalid),
      .bready(bready), .bresp(bresp), .wresp(wresp), .arvalid(arvalid), .arready(arready),
      .araddr(araddr), .rvalid(rvalid),
      .rready(rready), .rdata(rdata), .rresp(rresp), .hung(hung));

   initial
   begin
      aclk = 1'b0;
      forever
         #4 aclk = ~aclk;
   end

   // ======
   // Shared tasks
   task automatic chk(input logic [31:0] s, input logic [31:0] e);
      check_count++;
      if (s !== e)
      begin
         miscompares++;
         $display("MISMATCH %0t %h %h", $time, s, e);
      end
   endtask

   task automatic test_done;
      if (miscompares == 0 && check_count > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask

   task automatic w(input logic [7:0] a, input logic [7:0] d);
      dee_cpu_model_inst.wr(a, d);
   endtask

   task automatic rc(input logic [7:0] a, input logic [31:0] e);
      dee_cpu_model_inst.rd(a, v, rs);
      chk(v, e);
   endtask

   task automatic start_write(input logic [7:0] a, input logic [7:0] d);
      w(`DEE_OFS_ADR, a);
      w(`DEE_OFS_DAT, d);
      w(`DEE_OFS_CON, 8'h04);
      // No interrupt source here can split the key steps
      w(`DEE_OFS_KEY, `DEE_KEY_FIRST);
      w(`DEE_OFS_KEY, `DEE_KEY_SECOND);
      w(`DEE_OFS_CON, 8'h06);
   endtask

   // ======
   // Scenarios
   task automatic t_reset;
      for (int i = 0; i < 8; i++)
         rc(8'(4 * i), (i == 7) ? 32'h1 : 32'h0);
      dee_cpu_model_inst.rd(8'h20, v, rs);
      chk(32'(rs), 32'(`DEE_RESP_SLVERR));
      w(8'h20, 8'h00);
      chk(32'(wresp), 32'(`DEE_RESP_SLVERR));
   endtask

   task automatic t_pwrt;
      start_write(8'h5A, 8'hC3);
      rc(`DEE_OFS_CON, 32'h4);
      repeat (PWRT) @(posedge aclk);
   endtask

   task automatic t_write;
      cpb <= 1'b0;
      start_write(8'h5A, 8'hC3);
      w(`DEE_OFS_CON, 8'h00);
      chk(32'(wresp), 32'(`DEE_RESP_OKAY));
      rc(`DEE_OFS_CON, 32'h2);
      repeat (`DEE_WRITE_CYCLES) @(posedge aclk);
      rc(`DEE_OFS_CON, 32'h0);
      rc(`DEE_OFS_FLG, 32'h80);
      w(`DEE_OFS_ENA, 8'h80);
      chk(32'(irq), 32'h1);
      w(`DEE_OFS_FLG, 8'h00);
      chk(32'(irq), 32'h0);
      w(`DEE_OFS_DAT, 8'h00);
      rc(`DEE_OFS_DAT, 32'h0);
      w(`DEE_OFS_CON, 8'h01);
      rc(`DEE_OFS_DAT, 32'hC3);
      rc(`DEE_OFS_CON, 32'h0);
   endtask

   task automatic t_refuse;
      for (int i = 0; i < 3; i++)
      begin
         w(`DEE_OFS_CON, (i == 0) ? 8'h00 : 8'h04);
         w(`DEE_OFS_KEY, (i == 1) ? 8'h11 : `DEE_KEY_FIRST);
         if (i == 2)
            repeat (KW + 4) @(posedge aclk);
         w(`DEE_OFS_KEY, `DEE_KEY_SECOND);
         w(`DEE_OFS_CON, (i == 0) ? 8'h02 : 8'h06);
         rc(`DEE_OFS_CON, (i == 0) ? 32'h0 : 32'h4);
      end
      rc(`DEE_OFS_KEY, 32'h0);
   endtask

   task automatic t_abort;
      for (int i = 0; i < 3; i++)
      begin
         start_write(8'h5A, 8'h3C);
         rst_src <= dee_pkg::dee_rst_src_t'(3'(1 << i));
         @(posedge aclk);
         rst_src <= '0;
         rc(`DEE_OFS_CON, 32'hC);
         rc(`DEE_OFS_FLG, 32'h0);
      end
      w(`DEE_OFS_CON, 8'h01);
      rc(`DEE_OFS_DAT, 32'hC3);
   endtask

   always @(posedge hung)
   begin
      miscompares++;
      test_done();
   end

   initial
   begin
      miscompares = 0;
      check_count = 0;
      aresetn = 1'b0;
      rst_src = '0;
      cpb = 1'b1;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      t_reset();
      t_pwrt();
      t_write();
      t_refuse();
      t_abort();
      test_done();
   end
endmodule

`default_nettype wire
